/* hw/adcr_pkg.sv */
// Shared constants and types of the converter start and readout block.
// Assumes a 250 MHz core clock; the serial clock comes from the host.
package adcr_pkg;

  // Result word and core clock rate
  localparam int unsigned RES_W   = 18;
  localparam int unsigned CLK_MHZ = 250;

  // Conversion window in ns, and its cycle counts (min up, max down)
  localparam int unsigned T_CONV_MIN_NS = 500;
  localparam int unsigned T_CONV_MAX_NS = 2000;
  localparam int unsigned CONV_MIN_CYC  = (T_CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_MAX_CYC  = (T_CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W         = $clog2(CONV_MAX_CYC + 1);

  // Saturation codes
  localparam logic [RES_W-1:0] CODE_POS_MAX = 18'h1_FFFF;
  localparam logic [RES_W-1:0] CODE_NEG_MAX = 18'h2_0000;

  // Falling serial-clock edges per readout
  localparam logic [4:0] EDGES_PLAIN = 5'h12;
  localparam logic [4:0] EDGES_BUSY  = 5'h13;

  // Start bit level per style
  localparam logic START_BIT_SELECT = 1'b0;
  localparam logic START_BIT_CHAIN  = 1'b1;

  // Gray-coded sequence: acquire, convert, done, read
  typedef enum logic [1:0] {
    ST_ACQ  = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11,
    ST_READ = 2'b10
  } adcr_state_t;

  typedef enum logic {
    STYLE_CHAIN  = 1'b0,
    STYLE_SELECT = 1'b1
  } adcr_style_t;

  // Levels that cross into the core clock domain together
  typedef struct packed {
    logic convert_start;
    logic serial_data_in;
    logic sck;
    logic tog;
    logic shin;
  } adcr_async_t;

endpackage

/* hw/adcr_core.sv */
// Conversion start, style choice and serial result readout of the converter.
// Assumes the host drives convert_start, serial_data_in and the serial clock,
// and resolves the serial_data_out wire from its output enable.
//
// Overview of operation
// - Convert edge samples data-in: high select, low chain
// - Data-in tied to convert resolves to chain
// - Optional start bit flags end of conversion
// - Select style: busy if convert or data-in low
// - Chain style: busy if serial clock high
// - Data-in high: convert edge starts, selects, floats output
// - Started conversion always runs to completion
// - Conversion end enters acquisition, powers down
// - Convert fall drives MSB (select, no busy); clock falls shift
// - Each bit stands across both clock edges
// - Select, no busy: float after 18 falls, convert rise
// - Busy: output floats until conversion completes
// - Busy: start bit, MSB on first fall; select floats after 19th fall
// - Chain style shifts data-in into result register
// - Internal clock alone times the conversion
// - Result saturates at largest and most negative codes
`timescale 1ns/1ps
module adcr_core #(
  parameter int unsigned SAMPLE_W = 20,
  parameter int unsigned T_CONV_NS = 1000
) (
  // Core clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_arst_n,
  // Serial link
  input  wire logic                       i_sck,
  input  wire logic                       i_convert_start,
  input  wire logic                       i_serial_data_in,
  output logic                            o_serial_data_out,
  output logic                            o_serial_data_out_oe,
  // Analog front end result and power state
  input  wire logic signed [SAMPLE_W-1:0] i_sample,
  output logic                            o_acquire
);

  localparam int unsigned CONV_CYC = (T_CONV_NS * adcr_pkg::CLK_MHZ) / 1000;
  localparam logic [adcr_pkg::CNT_W-1:0] CONV_LAST =
    adcr_pkg::CNT_W'(CONV_CYC - 1);

  // Elaboration checks
  if (SAMPLE_W < adcr_pkg::RES_W) begin : g_bad_width
    $error("Sample narrower than result");
  end
  if (CONV_CYC < adcr_pkg::CONV_MIN_CYC || CONV_CYC > adcr_pkg::CONV_MAX_CYC) begin : g_bad_time
    $error("Conversion time outside window");
  end

  // Saturate the wide sample to the result code
  function automatic logic [adcr_pkg::RES_W-1:0] sat(input logic signed [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-adcr_pkg::RES_W:0] top;
    top = s[SAMPLE_W-1:adcr_pkg::RES_W-1];
    if (top == '0 || top == '1) begin
      sat = s[adcr_pkg::RES_W-1:0];
    end else if (s[SAMPLE_W-1]) begin
      sat = adcr_pkg::CODE_NEG_MAX;
    end else begin
      sat = adcr_pkg::CODE_POS_MAX;
    end
  endfunction

  // Link domain: edge toggle and chain input, taken on the falling clock
  logic lnk_tog_q;
  logic lnk_shin_q;
  always_ff @(negedge i_sck or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lnk_tog_q  <= 1'b0;
      lnk_shin_q <= 1'b0;
    end else begin
      lnk_tog_q  <= ~lnk_tog_q;
      lnk_shin_q <= i_serial_data_in;
    end
  end

  // Three-stage synchroniser with agreement filter
  adcr_pkg::adcr_async_t as_in;
  adcr_pkg::adcr_async_t as_s1_q;
  adcr_pkg::adcr_async_t as_s2_q;
  adcr_pkg::adcr_async_t as_s3_q;
  adcr_pkg::adcr_async_t as_f_q;
  adcr_pkg::adcr_async_t as_f_d;
  assign as_in  = '{convert_start: i_convert_start, serial_data_in: i_serial_data_in, sck: i_sck,
                    tog: lnk_tog_q, shin: lnk_shin_q};
  assign as_f_d = adcr_pkg::adcr_async_t'((as_s2_q & as_s3_q) | (as_f_q & (as_s2_q | as_s3_q)));
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      as_s1_q <= '0;
      as_s2_q <= '0;
      as_s3_q <= '0;
      as_f_q  <= '0;
    end else begin
      as_s1_q <= as_in;
      as_s2_q <= as_s1_q;
      as_s3_q <= as_s2_q;
      as_f_q  <= as_f_d;
    end
  end

  // Event decode
  wire cnv_rise = as_f_d.convert_start & ~as_f_q.convert_start;
  wire cnv_fall = ~as_f_d.convert_start & as_f_q.convert_start;
  wire sck_fall = as_f_d.tog ^ as_f_q.tog;

  // Control state
  adcr_pkg::adcr_state_t         st_q, st_d;
  adcr_pkg::adcr_style_t         style_q, style_d;
  logic                          busy_q, busy_d;
  logic [adcr_pkg::CNT_W-1:0]    cnt_q, cnt_d;
  logic [4:0]                    edges_q, edges_d;
  logic [adcr_pkg::RES_W-1:0]    sr_q, sr_d;
  logic                          sdo_q, sdo_d;
  logic                          oe_q, oe_d;
  logic                          acq_q;

  // Decode of conversion end and readout length
  wire                         conv_end  = (st_q == adcr_pkg::ST_CONV) && (cnt_q == CONV_LAST);
  wire [adcr_pkg::RES_W-1:0]   result    = sat(i_sample);
  wire                         sel_busy  = ~as_f_q.convert_start | ~as_f_q.serial_data_in;
  wire                         busy_end  = (style_q == adcr_pkg::STYLE_SELECT) ? sel_busy : busy_q;
  wire [4:0]                   edges_max = busy_q ? adcr_pkg::EDGES_BUSY : adcr_pkg::EDGES_PLAIN;
  wire [4:0]                   edges_inc = edges_q + 5'h01;
  wire                         start     = cnv_rise && (st_q != adcr_pkg::ST_CONV);
  wire                         start_bit = (style_q == adcr_pkg::STYLE_CHAIN) ?
                                           adcr_pkg::START_BIT_CHAIN : adcr_pkg::START_BIT_SELECT;
  // Without a start bit the output flop already holds the MSB, so the next bit sits one lower
  wire                         sr_tap    = busy_q ? sr_q[adcr_pkg::RES_W-1] :
                                           sr_q[adcr_pkg::RES_W-2];

  // Next-state logic
  always_comb begin
    st_d    = st_q;
    style_d = style_q;
    busy_d  = busy_q;
    cnt_d   = cnt_q;
    edges_d = edges_q;
    sr_d    = sr_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    case (st_q)
      adcr_pkg::ST_ACQ: begin
        // Both low: output driven low
        oe_d  = ~as_f_d.convert_start & ~as_f_d.serial_data_in;
        sdo_d = 1'b0;
      end
      adcr_pkg::ST_CONV: begin
        cnt_d = cnt_q + 1'b1;
        if (conv_end) begin
          busy_d  = busy_end;
          edges_d = '0;
          if (busy_end) begin
            st_d  = adcr_pkg::ST_READ;
            oe_d  = 1'b1;
            sdo_d = start_bit;
            sr_d  = result;
          end else if (style_q == adcr_pkg::STYLE_CHAIN) begin
            st_d  = adcr_pkg::ST_READ;
            oe_d  = 1'b1;
            sdo_d = result[adcr_pkg::RES_W-1];
            sr_d  = result;
          end else begin
            st_d = adcr_pkg::ST_DONE;
            sr_d = result;
          end
        end
      end
      adcr_pkg::ST_DONE: begin
        if (cnv_fall) begin
          st_d  = adcr_pkg::ST_READ;
          oe_d  = 1'b1;
          sdo_d = sr_q[adcr_pkg::RES_W-1];
        end
      end
      adcr_pkg::ST_READ: begin
        if (sck_fall) begin
          // Bit changes only after the fall, so it stands across both edges
          sdo_d   = sr_tap;
          sr_d    = {sr_q[adcr_pkg::RES_W-2:0], as_f_d.shin};
          edges_d = edges_inc;
          if (edges_inc == edges_max && style_q == adcr_pkg::STYLE_SELECT) begin
            st_d = adcr_pkg::ST_ACQ;
            oe_d = 1'b0;
          end
        end
      end
      default: begin
        st_d = adcr_pkg::ST_ACQ;
        oe_d = 1'b0;
      end
    endcase
    if (start) begin
      st_d    = adcr_pkg::ST_CONV;
      style_d = adcr_pkg::adcr_style_t'(as_f_q.serial_data_in);
      busy_d  = ~as_f_q.serial_data_in & as_f_q.sck;
      cnt_d   = '0;
      oe_d    = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q    <= adcr_pkg::ST_ACQ;
      style_q <= adcr_pkg::STYLE_SELECT;
      busy_q  <= 1'b0;
      cnt_q   <= '0;
      edges_q <= '0;
      sr_q    <= '0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      acq_q   <= 1'b1;
    end else begin
      st_q    <= st_d;
      style_q <= style_d;
      busy_q  <= busy_d;
      cnt_q   <= cnt_d;
      edges_q <= edges_d;
      sr_q    <= sr_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      acq_q   <= (st_d != adcr_pkg::ST_CONV);
    end
  end

  // Outputs
  assign o_serial_data_out    = sdo_q;
  assign o_serial_data_out_oe = oe_q;
  assign o_acquire            = acq_q;

  // Checks
  sequence s_start;
    start ##1 (st_q == adcr_pkg::ST_CONV);
  endsequence

  property p_style;
    @(posedge i_clock) disable iff (!i_arst_n)
      start |=> (style_q == adcr_pkg::adcr_style_t'($past(as_f_q.serial_data_in)));
  endproperty
  a_style: assert property (p_style) else $error("Style not taken at convert edge");

  property p_tied;
    @(posedge i_clock) disable iff (!i_arst_n)
      (start && !as_f_q.serial_data_in) |=> (style_q == adcr_pkg::STYLE_CHAIN);
  endproperty
  a_tied: assert property (p_tied) else $error("Tied inputs not chain");

  property p_float_start;
    @(posedge i_clock) disable iff (!i_arst_n)
      s_start |-> !o_serial_data_out_oe && !o_acquire;
  endproperty
  a_float_start: assert property (p_float_start) else $error("Output driven at start");

  property p_run;
    @(posedge i_clock) disable iff (!i_arst_n)
      (st_q == adcr_pkg::ST_CONV && !conv_end) |=> (st_q == adcr_pkg::ST_CONV);
  endproperty
  a_run: assert property (p_run) else $error("Conversion cut short");

  // Cycles spent converting, counted apart from the conversion counter
  logic [adcr_pkg::CNT_W-1:0] chk_len_q;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chk_len_q <= '0;
    end else if (st_q != adcr_pkg::ST_CONV) begin
      chk_len_q <= '0;
    end else begin
      chk_len_q <= chk_len_q + 1'b1;
    end
  end

  property p_len;
    @(posedge i_clock) disable iff (!i_arst_n)
      (st_q == adcr_pkg::ST_CONV) |-> (conv_end == (chk_len_q == CONV_LAST));
  endproperty
  a_len: assert property (p_len) else $error("Conversion length wrong");

  property p_busy_sel;
    @(posedge i_clock) disable iff (!i_arst_n)
      (conv_end && style_q == adcr_pkg::STYLE_SELECT && sel_busy)
        |=> busy_q && o_serial_data_out_oe && (o_serial_data_out == 1'b0);
  endproperty
  a_busy_sel: assert property (p_busy_sel) else $error("Select busy start bit missing");

  property p_conv_float;
    @(posedge i_clock) disable iff (!i_arst_n)
      (st_q == adcr_pkg::ST_CONV) |-> !o_serial_data_out_oe;
  endproperty
  a_conv_float: assert property (p_conv_float) else $error("Output driven in conversion");

  property p_msb;
    @(posedge i_clock) disable iff (!i_arst_n)
      (st_q == adcr_pkg::ST_DONE && cnv_fall && !start)
        |=> o_serial_data_out_oe && (o_serial_data_out == $past(sr_q[adcr_pkg::RES_W-1]));
  endproperty
  a_msb: assert property (p_msb) else $error("MSB not driven on convert fall");

  property p_end;
    @(posedge i_clock) disable iff (!i_arst_n)
      (st_q == adcr_pkg::ST_READ && sck_fall && edges_inc == edges_max
        && style_q == adcr_pkg::STYLE_SELECT) |=> !o_serial_data_out_oe;
  endproperty
  a_end: assert property (p_end) else $error("Output not floated after last edge");

  property p_chain_busy;
    @(posedge i_clock) disable iff (!i_arst_n)
      (start && !as_f_q.serial_data_in) |=> (busy_q == $past(as_f_q.sck));
  endproperty
  a_chain_busy: assert property (p_chain_busy) else $error("Chain busy choice wrong");

endmodule // adcr_core

/* test/adcr_host.sv */
// Host model of the serial link: drives convert, data-in and the serial clock.
// Assumes a free-running link clock; the serial clock moves inside frames and around a chain busy start.
`timescale 1ns/1ps
module adcr_host (
  // Link clock
  input  wire logic i_link_clk,
  // Device output and its enable
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  // Host pins and the resolved data wire
  output logic      o_sck,
  output logic      o_cnv,
  output logic      o_sdi,
  output logic      o_line
);
  // Pull-up holds the wire high while the device floats it
  assign o_line = i_sdo_oe ? i_sdo : 1'b1;
  // Quiet pins at time zero
  initial begin
    o_sck = 1'b0;
    o_cnv = 1'b0;
    o_sdi = 1'b0;
  end
  // Half serial period, long enough for the core synchroniser
  task automatic half();
    repeat (6) @(negedge i_link_clk);
  endtask
  // Change pin levels, then give the core time to see them
  task automatic set(input logic convert_start, input logic serial_data_in, input logic sck);
    @(negedge i_link_clk);
    o_cnv = convert_start;
    o_sdi = serial_data_in;
    o_sck = sck;
    half();
  endtask
  // Clock n bits; capture at each rise and just before each fall
  task automatic shift(input int n, input logic [39:0] din,
                       output logic [39:0] q_r, output logic [39:0] q_f);
    q_r = '0;
    q_f = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge i_link_clk);
      o_sck  = 1'b1;
      q_r[i] = o_line;
      o_sdi  = din[i];
      half();
      q_f[i] = o_line;
      @(negedge i_link_clk);
      o_sck = 1'b0;
      half();
    end
  endtask
endmodule // adcr_host

/* test/testbench.sv */
// Self-checking bench of the converter start and readout block.
// Assumes the host model above; conversion shortened to 500 ns (125 cycles).
`timescale 1ns/1ps
module testbench;
  logic               i_clock  = 1'b0;
  logic               i_arst_n = 1'b0;
  logic               link_clk = 1'b0;
  logic signed [19:0] sample   = '0;
  logic [39:0]        qr;
  logic [39:0]        qf;
  wire logic          sck, convert_start, serial_data_in, serial_data_out, sdo_oe, acq, line;
  int                 fail_count = 0;
  int                 num_checks = 0;
  // Core clock 250 MHz; link clock 6 ns with an odd phase
  always #2 i_clock = ~i_clock;
  initial #1.3 forever #3 link_clk = ~link_clk;
  adcr_core #(.SAMPLE_W(20), .T_CONV_NS(500)) adcr_core_inst (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_sck(sck), .i_convert_start(convert_start),
    .i_serial_data_in(serial_data_in), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(sdo_oe),
    .i_sample(sample), .o_acquire(acq));
  adcr_host adcr_host_inst (.i_link_clk(link_clk), .i_sdo(serial_data_out), .i_sdo_oe(sdo_oe),
    .o_sck(sck), .o_cnv(convert_start), .o_sdi(serial_data_in), .o_line(line));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      fail_count++;
    end
  endtask
  // Bounded wait on the enable (which=0) or the acquire flag (which=1)
  task automatic wait_sig(input logic which, input logic lvl, input int lim);
    for (int k = 0; k < lim && (which ? acq : sdo_oe) !== lvl; k++) @(negedge i_clock);
    if ((which ? acq : sdo_oe) !== lvl) begin
      $display("MISMATCH t=%0t wait ran out", $time);
      fail_count++;
      stop_test();
    end
  endtask
  // Start a conversion and see it begin with the output floating
  task automatic start(input logic sdi_v, input logic sck_v);
    adcr_host_inst.set(1'b1, sdi_v, sck_v);
    wait_sig(1'b1, 1'b0, 30);
    check(sdo_oe, 1'b0, "float at start");
  endtask
  task automatic t_select_plain();
    @(negedge i_clock) sample = 20'sh0_A5C3;
    adcr_host_inst.set(1'b0, 1'b1, 1'b0);
    start(1'b1, 1'b0);
    adcr_host_inst.set(1'b0, 1'b1, 1'b0);
    adcr_host_inst.set(1'b1, 1'b1, 1'b0);
    check(acq, 1'b0, "conversion kept running");
    wait_sig(1'b1, 1'b1, 200);
    check(sdo_oe, 1'b0, "no busy while cnv high");
    adcr_host_inst.set(1'b0, 1'b1, 1'b0);
    check(sdo_oe, 1'b1, "msb driven on cnv fall");
    adcr_host_inst.shift(18, 40'hFF_FFFF_FFFF, qr, qf);
    check(qr, 40'h0_A5C3, "plain select word");
    check(qf, qr, "bit held across edges");
    check(sdo_oe, 1'b0, "float after 18th fall");
    $display("test select plain done");
  endtask
  task automatic t_select_busy();
    @(negedge i_clock) sample = 20'sh7_FFFF;
    start(1'b1, 1'b0);
    adcr_host_inst.set(1'b0, 1'b1, 1'b0);
    repeat (40) @(negedge i_clock);
    check(sdo_oe, 1'b0, "float until done");
    wait_sig(1'b0, 1'b1, 300);
    check(acq, 1'b1, "acquire after conversion");
    check(line, 1'b0, "select start bit");
    adcr_host_inst.shift(19, 40'hFF_FFFF_FFFF, qr, qf);
    check(qr, {21'h0, 1'b0, 18'h1_FFFF}, "busy word, top clip");
    check(sdo_oe, 1'b0, "float after 19th fall");
    $display("test select busy done");
  endtask
  task automatic t_chain_plain();
    @(negedge i_clock) sample = 20'sh8_0000;
    adcr_host_inst.set(1'b0, 1'b0, 1'b0);
    check({sdo_oe, line}, 2'b10, "idle drive low");
    start(1'b0, 1'b0);
    wait_sig(1'b0, 1'b1, 300);
    adcr_host_inst.shift(19, 40'h7_FFFF, qr, qf);
    check(qr, {21'h0, 18'h2_0000, 1'b1}, "chain word then shifted in");
    check(sdo_oe, 1'b1, "chain keeps driving");
    $display("test chain plain done");
  endtask
  task automatic t_chain_busy();
    @(negedge i_clock) sample = 20'sh0_0001;
    adcr_host_inst.set(1'b0, 1'b0, 1'b1);
    start(1'b1, 1'b1);
    adcr_host_inst.set(1'b1, 1'b1, 1'b0);
    wait_sig(1'b0, 1'b1, 300);
    check(line, 1'b1, "chain start bit");
    adcr_host_inst.shift(19, 40'h7_FFFF, qr, qf);
    check(qr, {21'h0, 1'b1, 18'h0_0001}, "chain busy word");
    adcr_host_inst.set(1'b0, 1'b0, 1'b0);
    $display("test chain busy done");
  endtask
  // Reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge i_clock);
    @(negedge i_clock) i_arst_n = 1'b1;
    check({sdo_oe, acq}, 2'b01, "reset state");
    t_select_plain();
    t_select_busy();
    t_chain_plain();
    t_chain_busy();
    stop_test();
  end
endmodule // testbench
